// ### gpfm_pads.sv
// Pad model for the sixteen port pins
`timescale 1ns/1ps
`default_nettype none

module gpfm_pads
	import gpfm_pkg::*;
(
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe,
	input wire logic [15:0] ext_en,
	input wire logic [15:0] ext_val,
	output logic [15:0] pad
);
	// Mux drive first, then an outside driver, else the pull-up
	always_comb begin
		for (int i = 0; i < GPFM_NPINS; i++) begin
			pad[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'h1);
		end
	end
endmodule

`default_nettype wire

// ### gpfm_pkg.sv
// Package with register map, field layout and routing constants of the port function mux
package gpfm_pkg;

	// Byte addresses of the three port function-select registers
	localparam logic [31:0] GPFM_PORT0_SEL_ADDR = 32'hFFFF0D00;
	localparam logic [31:0] GPFM_PORT1_SEL_ADDR = 32'hFFFF0D04;
	localparam logic [31:0] GPFM_PORT2_SEL_ADDR = 32'hFFFF0D08;

	// Reset value of every function-select register
	localparam logic [31:0] GPFM_SEL_RESET = 32'h00000000;

	// Pins per port and position of each port in the flat pin vector
	localparam int GPFM_P0_PINS = 7;
	localparam int GPFM_P1_PINS = 7;
	localparam int GPFM_P2_PINS = 2;
	localparam int GPFM_NPINS = 16;
	localparam int GPFM_P0_BASE = 0;
	localparam int GPFM_P1_BASE = 7;
	localparam int GPFM_P2_BASE = 14;

	// Lowest bit of each pin's two-bit field
	localparam int GPFM_FLD0_LSB = 0;
	localparam int GPFM_FLD1_LSB = 4;
	localparam int GPFM_FLD2_LSB = 8;
	localparam int GPFM_FLD3_LSB = 12;
	localparam int GPFM_FLD4_LSB = 16;
	localparam int GPFM_FLD5_LSB = 20;
	localparam int GPFM_FLD6_LSB = 24;

	// Field codes
	localparam logic [1:0] GPFM_CODE_GPIO = 2'h0;
	localparam logic [1:0] GPFM_CODE_ALT = 2'h1;

	// Level handed to a peripheral input while its pin is not routed to it
	localparam logic GPFM_SS_IDLE = 1'h1;
	localparam logic GPFM_SCLK_IDLE = 1'h0;
	localparam logic GPFM_DATA_IDLE = 1'h0;
	localparam logic GPFM_CTS_IDLE = 1'h1;
	localparam logic GPFM_RX_IDLE = 1'h1;
	localparam logic GPFM_SYNC_IDLE = 1'h0;
	localparam logic GPFM_TRIP_IDLE = 1'h0;

	// Keeps one bit per pin: set only for the alternate code, other codes fall back to GPIO
	function automatic logic [6:0] gpfm_unpack(input logic [31:0] w);
		logic [6:0] s;
		s = 7'h00;
		s[0] = (w[GPFM_FLD0_LSB +: 2] == GPFM_CODE_ALT);
		s[1] = (w[GPFM_FLD1_LSB +: 2] == GPFM_CODE_ALT);
		s[2] = (w[GPFM_FLD2_LSB +: 2] == GPFM_CODE_ALT);
		s[3] = (w[GPFM_FLD3_LSB +: 2] == GPFM_CODE_ALT);
		s[4] = (w[GPFM_FLD4_LSB +: 2] == GPFM_CODE_ALT);
		s[5] = (w[GPFM_FLD5_LSB +: 2] == GPFM_CODE_ALT);
		s[6] = (w[GPFM_FLD6_LSB +: 2] == GPFM_CODE_ALT);
		return s;
	endfunction

	// Rebuilds the register image; reserved pairs stay zero
	function automatic logic [31:0] gpfm_pack(input logic [6:0] s);
		logic [31:0] w;
		w = GPFM_SEL_RESET;
		for (int i = 0; i < 7; i++) begin
			w[4 * i] = s[i];
		end
		return w;
	endfunction

endpackage

// ### gpfm_port_mux.sv
// One port's output mux and peripheral input steering
`timescale 1ns/1ps
`default_nettype none

module gpfm_port_mux
	import gpfm_pkg::*;
#(
	parameter int W = 7
) (
	input wire logic [W-1:0] sel,
	input wire logic [W-1:0] pin_in,
	input wire logic [W-1:0] gpio_out,
	input wire logic [W-1:0] gpio_oe,
	input wire logic [W-1:0] alt_out,
	input wire logic [W-1:0] alt_oe,
	input wire logic [W-1:0] alt_idle,
	output logic [W-1:0] pin_out,
	output logic [W-1:0] pin_oe,
	output logic [W-1:0] alt_in,
	output logic [W-1:0] gpio_fn_in
);

	// Per pin choice between GPIO and the alternate function
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (sel[i]) begin
				// Alternate function owns the pad
				pin_out[i] = alt_out[i];
				pin_oe[i] = alt_oe[i];
				alt_in[i] = pin_in[i];
				gpio_fn_in[i] = 1'h0;
			end else begin
				// Plain GPIO; shared interrupt and clock inputs see the pad
				pin_out[i] = gpio_out[i];
				pin_oe[i] = gpio_oe[i];
				alt_in[i] = alt_idle[i];
				gpio_fn_in[i] = pin_in[i];
			end
		end
	end

endmodule

`default_nettype wire

// ### gpfm_top.sv
// Port pin function multiplexer with its three function-select registers
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Reset leaves all pins in GPIO
// - Power-save freezes configuration and driven levels
// - Three ports of seven, seven, two pins
// - Only select-register fields choose the function
// - Code 00 gives GPIO plus shared inputs
// - Port0 pins0-3 carry SPI with code 01
// - Port0 pin4 drives pulse out 1
// - UART handshake and serial lines on 01
// - Port1 pins2,3 feed sync and trip
// - Remaining pins drive pulse outputs 2-5,0
// - Bits 1:0 select pin 0
// - Bits 5:4 select pin 1
// - Bits 9:8 select pin 2
// - Bits 13:12 select pin 3
// - Bits 17:16 select pin 4
// - Bits 21:20 select pin 5
// - Bits 25:24 select pin 6
module gpfm_top
	import gpfm_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	input wire logic power_save,
	input wire logic [15:0] pin_in,
	output logic [15:0] pin_out,
	output logic [15:0] pin_oe,
	input wire logic [15:0] gpio_out,
	input wire logic [15:0] gpio_oe,
	output logic [15:0] gpio_in,
	input wire logic spi_ss_out,
	input wire logic spi_ss_oe,
	output logic spi_ss_in,
	input wire logic spi_sclk_out,
	input wire logic spi_sclk_oe,
	output logic spi_sclk_in,
	input wire logic spi_miso_out,
	input wire logic spi_miso_oe,
	output logic spi_miso_in,
	input wire logic spi_mosi_out,
	input wire logic spi_mosi_oe,
	output logic spi_mosi_in,
	output logic uart_cts_in,
	input wire logic uart_rts_out,
	output logic uart_serial_in,
	input wire logic uart_serial_out,
	output logic pwm_sync_in,
	output logic pwm_trip_in,
	input wire logic pulse_out_0,
	input wire logic pulse_out_1,
	input wire logic pulse_out_2,
	input wire logic pulse_out_3,
	input wire logic pulse_out_4,
	input wire logic pulse_out_5,
	output logic ext_interrupt_in0,
	output logic ext_interrupt_in1,
	output logic ext_interrupt_in2,
	output logic ext_interrupt_in3,
	output logic external_clock_in,
	output logic timer_capture_in
);

	// Whole registered state of the block
	typedef struct packed {
		logic [6:0] sel0; // Port 0 alternate-function bits
		logic [6:0] sel1; // Port 1 alternate-function bits
		logic [1:0] sel2; // Port 2 alternate-function bits
		logic [31:0] rdata; // Read data, valid one cycle after the strobe
		logic [15:0] pout; // Pad output levels
		logic [15:0] poe; // Pad output enables
		logic [15:0] gin; // Pad levels seen by GPIO
		logic [6:0] p0_in; // Port 0 peripheral inputs
		logic [6:0] p1_in; // Port 1 peripheral inputs
		logic [3:0] ext_int; // External interrupt inputs
		logic ext_clk; // External clock input
		logic tcap; // Timer capture input
	} gpfm_state_type;

	gpfm_state_type q; // Registered state
	gpfm_state_type d; // Next state

	// Alternate-function drive of each port
	logic [6:0] alt0_out;
	logic [6:0] alt0_oe;
	logic [6:0] alt1_out;
	logic [6:0] alt1_oe;
	logic [1:0] alt2_out;
	logic [1:0] alt2_oe;

	// Idle levels of peripheral inputs per pin
	logic [6:0] idle0;
	logic [6:0] idle1;

	// Mux results per port
	logic [6:0] m0_out;
	logic [6:0] m0_oe;
	logic [6:0] m0_alt_in;
	logic [6:0] m0_fn_in;
	logic [6:0] m1_out;
	logic [6:0] m1_oe;
	logic [6:0] m1_alt_in;
	logic [6:0] m1_fn_in;
	logic [1:0] m2_out;
	logic [1:0] m2_oe;
	logic [1:0] m2_alt_in;
	logic [1:0] m2_fn_in;

	// Port 0: SPI on pins 0-3, pulse out 1, UART handshake on 5 and 6
	assign alt0_out = {uart_rts_out, 1'h0, pulse_out_1, spi_mosi_out, spi_miso_out, spi_sclk_out, spi_ss_out};
	assign alt0_oe = {1'h1, 1'h0, 1'h1, spi_mosi_oe, spi_miso_oe, spi_sclk_oe, spi_ss_oe};
	assign idle0 = {1'h0, GPFM_CTS_IDLE, 1'h0, GPFM_DATA_IDLE, GPFM_DATA_IDLE, GPFM_SCLK_IDLE, GPFM_SS_IDLE};

	// Port 1: UART serial lines, sync and trip inputs, pulse outs 2-4
	assign alt1_out = {pulse_out_4, pulse_out_3, pulse_out_2, 1'h0, 1'h0, uart_serial_out, 1'h0};
	assign alt1_oe = {1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
	assign idle1 = {1'h0, 1'h0, 1'h0, GPFM_TRIP_IDLE, GPFM_SYNC_IDLE, 1'h0, GPFM_RX_IDLE};

	// Port 2: pulse outs 0 and 5
	assign alt2_out = {pulse_out_5, pulse_out_0};
	assign alt2_oe = 2'h3;

	// One mux per port, seven, seven and two pins wide
	gpfm_port_mux #(.W(GPFM_P0_PINS)) u_port0 (
		.sel(q.sel0),
		.pin_in(pin_in[GPFM_P0_BASE +: GPFM_P0_PINS]),
		.gpio_out(gpio_out[GPFM_P0_BASE +: GPFM_P0_PINS]),
		.gpio_oe(gpio_oe[GPFM_P0_BASE +: GPFM_P0_PINS]),
		.alt_out(alt0_out),
		.alt_oe(alt0_oe),
		.alt_idle(idle0),
		.pin_out(m0_out),
		.pin_oe(m0_oe),
		.alt_in(m0_alt_in),
		.gpio_fn_in(m0_fn_in)
	);

	gpfm_port_mux #(.W(GPFM_P1_PINS)) u_port1 (
		.sel(q.sel1),
		.pin_in(pin_in[GPFM_P1_BASE +: GPFM_P1_PINS]),
		.gpio_out(gpio_out[GPFM_P1_BASE +: GPFM_P1_PINS]),
		.gpio_oe(gpio_oe[GPFM_P1_BASE +: GPFM_P1_PINS]),
		.alt_out(alt1_out),
		.alt_oe(alt1_oe),
		.alt_idle(idle1),
		.pin_out(m1_out),
		.pin_oe(m1_oe),
		.alt_in(m1_alt_in),
		.gpio_fn_in(m1_fn_in)
	);

	gpfm_port_mux #(.W(GPFM_P2_PINS)) u_port2 (
		.sel(q.sel2),
		.pin_in(pin_in[GPFM_P2_BASE +: GPFM_P2_PINS]),
		.gpio_out(gpio_out[GPFM_P2_BASE +: GPFM_P2_PINS]),
		.gpio_oe(gpio_oe[GPFM_P2_BASE +: GPFM_P2_PINS]),
		.alt_out(alt2_out),
		.alt_oe(alt2_oe),
		.alt_idle(2'h0),
		.pin_out(m2_out),
		.pin_oe(m2_oe),
		.alt_in(m2_alt_in),
		.gpio_fn_in(m2_fn_in)
	);

	// Next-state logic: register writes, read data, pad drive, input steering
	always_comb begin
		d = q;
		// Writes are refused while the chip sleeps so the setup stays put
		if (bus_wr && !power_save) begin
			case (bus_addr)
				GPFM_PORT0_SEL_ADDR: begin
					d.sel0 = gpfm_unpack(bus_wdata);
				end
				GPFM_PORT1_SEL_ADDR: begin
					d.sel1 = gpfm_unpack(bus_wdata);
				end
				GPFM_PORT2_SEL_ADDR: begin
					d.sel2 = 2'(gpfm_unpack(bus_wdata));
				end
				default: begin
					// Unmapped write has no effect
				end
			endcase
		end
		// Read data stands only in the cycle after the strobe
		d.rdata = 32'h00000000;
		if (bus_rd) begin
			case (bus_addr)
				GPFM_PORT0_SEL_ADDR: begin
					d.rdata = gpfm_pack(q.sel0);
				end
				GPFM_PORT1_SEL_ADDR: begin
					d.rdata = gpfm_pack(q.sel1);
				end
				GPFM_PORT2_SEL_ADDR: begin
					d.rdata = gpfm_pack({5'h00, q.sel2});
				end
				default: begin
					// Unmapped read returns zero
				end
			endcase
		end
		// Pad drive freezes during power-save
		if (!power_save) begin
			d.pout = {m2_out, m1_out, m0_out};
			d.poe = {m2_oe, m1_oe, m0_oe};
		end
		// Input side keeps sampling
		d.gin = pin_in;
		d.p0_in = m0_alt_in;
		d.p1_in = m1_alt_in;
		d.ext_int = {m2_fn_in[1], m2_fn_in[0], m1_fn_in[0], m0_fn_in[4]};
		d.ext_clk = m2_fn_in[0];
		d.tcap = m1_fn_in[0];
	end

	// State register; reset puts every pin in GPIO
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			q.sel0 <= GPFM_SEL_RESET[6:0];
			q.sel1 <= GPFM_SEL_RESET[6:0];
			q.sel2 <= GPFM_SEL_RESET[1:0];
			q.rdata <= 32'h00000000;
			q.pout <= 16'h0000;
			q.poe <= 16'h0000;
			q.gin <= 16'h0000;
			q.p0_in <= 7'h00;
			q.p1_in <= 7'h00;
			q.ext_int <= 4'h0;
			q.ext_clk <= 1'h0;
			q.tcap <= 1'h0;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign bus_rdata = q.rdata;
	assign pin_out = q.pout;
	assign pin_oe = q.poe;
	assign gpio_in = q.gin;
	assign spi_ss_in = q.p0_in[0];
	assign spi_sclk_in = q.p0_in[1];
	assign spi_miso_in = q.p0_in[2];
	assign spi_mosi_in = q.p0_in[3];
	assign uart_cts_in = q.p0_in[5];
	assign uart_serial_in = q.p1_in[0];
	assign pwm_sync_in = q.p1_in[2];
	assign pwm_trip_in = q.p1_in[3];
	assign ext_interrupt_in0 = q.ext_int[0];
	assign ext_interrupt_in1 = q.ext_int[1];
	assign ext_interrupt_in2 = q.ext_int[2];
	assign ext_interrupt_in3 = q.ext_int[3];
	assign external_clock_in = q.ext_clk;
	assign timer_capture_in = q.tcap;

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_save_holds_pads: assert property (power_save |=> $stable(pin_out) && $stable(pin_oe))
		else $error("pad drive changed during power-save");
	a_save_blocks_write: assert property (power_save && bus_wr |=> $stable(q.sel0) && $stable(q.sel1) && $stable(q.sel2))
		else $error("select register changed during power-save");
	a_reserved_read_zero: assert property (bus_rd |=> (bus_rdata & 32'hFEEEEEEE) == 32'h00000000)
		else $error("reserved bits read non-zero");
	a_code_ten_ignored: assert property (bus_wr && !power_save && bus_addr == GPFM_PORT1_SEL_ADDR
		&& bus_wdata[13:12] == 2'h2 |=> !q.sel1[3])
		else $error("code 10 selected alternate function");
	a_field_top_pin: assert property (bus_wr && !power_save && bus_addr == GPFM_PORT0_SEL_ADDR
		|=> q.sel0[6] == ($past(bus_wdata[25:24]) == 2'h1))
		else $error("pin 6 field misplaced");
	a_write_then_read: assert property (bus_wr && !power_save && bus_addr == GPFM_PORT2_SEL_ADDR
		##1 bus_rd && bus_addr == GPFM_PORT2_SEL_ADDR |=> bus_rdata[1:0] == ($past(bus_wdata[1:0], 2) == 2'h1))
		else $error("port 2 pin 0 read back wrong");
	a_spi_clock_route: assert property (q.sel0[1] && !power_save |=> pin_oe[1] == $past(spi_sclk_oe))
		else $error("serial clock enable not routed");
	a_pulse1_route: assert property (q.sel0[4] && !power_save |=> pin_out[4] == $past(pulse_out_1))
		else $error("pulse out 1 not on port 0 pin 4");
	a_int0_gpio_mode: assert property (!q.sel0[4] |=> ext_interrupt_in0 == $past(pin_in[4]))
		else $error("interrupt 0 not fed in GPIO mode");
	a_uart_rx_route: assert property (q.sel1[0] |=> uart_serial_in == $past(pin_in[7]))
		else $error("serial input not routed");
	a_trip_idle: assert property (!q.sel1[3] |=> pwm_trip_in == GPFM_TRIP_IDLE)
		else $error("trip fed while pin in GPIO");
	a_pulse0_route: assert property (q.sel2[0] && !power_save |=> pin_oe[14] && pin_out[14] == $past(pulse_out_0))
		else $error("pulse out 0 not on port 2 pin 0");

	// Read data falls back to zero when no read was taken
	a_rdata_one_cycle: assert property (!bus_rd |=> bus_rdata == 32'h00000000)
		else $error("read data stood without a read strobe");
	// Serial clock pad reaches the SPI only when selected
	a_sclk_in_route: assert property (q.sel0[1] |=> spi_sclk_in == $past(pin_in[1]))
		else $error("serial clock input not routed");
	// Slave data out drives port 0 pin 2
	a_miso_route: assert property (q.sel0[2] && !power_save
		|=> pin_oe[2] == $past(spi_miso_oe) && pin_out[2] == $past(spi_miso_out))
		else $error("slave data out not on port 0 pin 2");
	// Clear-to-send rests high while its pin is plain GPIO
	a_cts_idle: assert property (!q.sel0[5] |=> uart_cts_in == GPFM_CTS_IDLE)
		else $error("clear to send not idle in GPIO");
	// Request-to-send drives port 0 pin 6
	a_rts_route: assert property (q.sel0[6] && !power_save
		|=> pin_oe[6] && pin_out[6] == $past(uart_rts_out))
		else $error("request to send not on port 0 pin 6");
	// Serial output drives port 1 pin 1
	a_tx_route: assert property (q.sel1[1] && !power_save
		|=> pin_oe[8] && pin_out[8] == $past(uart_serial_out))
		else $error("serial output not on port 1 pin 1");
	// Sync input taken from port 1 pin 2
	a_sync_route: assert property (q.sel1[2] |=> pwm_sync_in == $past(pin_in[9]))
		else $error("sync input not routed");
	// Pulse out 2 drives port 1 pin 4
	a_pulse2_route: assert property (q.sel1[4] && !power_save
		|=> pin_oe[11] && pin_out[11] == $past(pulse_out_2))
		else $error("pulse out 2 not on port 1 pin 4");
	// Pulse out 5 drives port 2 pin 1
	a_pulse5_route: assert property (q.sel2[1] && !power_save
		|=> pin_oe[15] && pin_out[15] == $past(pulse_out_5))
		else $error("pulse out 5 not on port 2 pin 1");
	// GPIO block owns the pad when the field is 00
	a_gpio_drive: assert property (!q.sel1[4] && !power_save
		|=> pin_out[11] == $past(gpio_out[11]) && pin_oe[11] == $past(gpio_oe[11]))
		else $error("GPIO drive not on port 1 pin 4");
	// Shared interrupt and clock inputs rest low in alternate mode
	a_clock_in_alt: assert property (q.sel2[0] |=> !ext_interrupt_in2 && !external_clock_in)
		else $error("shared inputs fed in alternate mode");

	c_spi_selected: cover property (q.sel0[3:0] == 4'hF);
	c_save_entered: cover property (!power_save ##1 power_save);
	c_port1_alt_read: cover property (bus_rd && bus_addr == GPFM_PORT1_SEL_ADDR && q.sel1 != 7'h00);
	c_uart_selected: cover property (q.sel0[6:5] == 2'h3 && q.sel1[1:0] == 2'h3);
	c_save_write: cover property (power_save && bus_wr);

endmodule

`default_nettype wire

// ### test_gpio_port_function_mux.sv
// Self-checking bench for the port function mux
`timescale 1ns/1ps
`default_nettype none

module test_gpio_port_function_mux
	import gpfm_pkg::*;
;
	logic mclk, reset, bus_wr, bus_rd, power_save;
	logic [31:0] bus_addr, bus_wdata, bus_rdata, e_rd;
	logic [15:0] pin_in, pin_out, pin_oe, gpio_out, gpio_oe, gpio_in, ext_en, ext_val, pr;
	logic [15:0] sel_m, e_out, e_oe, e_gin;
	logic [13:0] fin, e_fin;
	logic [31:0] adr [4];
	int n_mismatch = 0;
	int tests_run = 0;
	// Alternate drive and enable per pin, taken from the peripheral side
	wire [15:0] ao = {pr[15], pr[10], pr[14], pr[13], pr[12], 1'h0, 1'h0, pr[9], 1'h0, pr[8], 1'h0, pr[11],
		pr[6], pr[4], pr[2], pr[0]};
	wire [15:0] aoe = {5'h1F, 2'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, pr[7], pr[5], pr[3], pr[1]};

	gpfm_top dut_u (.mclk(mclk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .power_save(power_save), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
		.spi_ss_out(pr[0]), .spi_ss_oe(pr[1]), .spi_ss_in(fin[0]), .spi_sclk_out(pr[2]), .spi_sclk_oe(pr[3]),
		.spi_sclk_in(fin[1]), .spi_miso_out(pr[4]), .spi_miso_oe(pr[5]), .spi_miso_in(fin[2]),
		.spi_mosi_out(pr[6]), .spi_mosi_oe(pr[7]), .spi_mosi_in(fin[3]), .uart_cts_in(fin[4]),
		.uart_rts_out(pr[8]), .uart_serial_in(fin[5]), .uart_serial_out(pr[9]), .pwm_sync_in(fin[6]),
		.pwm_trip_in(fin[7]), .pulse_out_0(pr[10]), .pulse_out_1(pr[11]), .pulse_out_2(pr[12]),
		.pulse_out_3(pr[13]), .pulse_out_4(pr[14]), .pulse_out_5(pr[15]), .ext_interrupt_in0(fin[8]),
		.ext_interrupt_in1(fin[9]), .ext_interrupt_in2(fin[10]), .ext_interrupt_in3(fin[11]),
		.external_clock_in(fin[12]), .timer_capture_in(fin[13]));

	gpfm_pads pads_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pad(pin_in));

	// Clock at 40 MHz
	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end

	// Expected register image of one port
	function automatic logic [31:0] img(input int p);
		logic [31:0] w;
		w = 32'h0;
		for (int i = 0; i < 7; i++) begin
			if (p < 2 || i < 2) w[4 * i] = sel_m[7 * p + i];
		end
		return w;
	endfunction

	// Counts and reports one comparison
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Prints the verdict and ends the run
	task automatic give_verdict();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One bus cycle, entered and left at a rising edge
	task automatic op(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
		bus_wr <= w;
		bus_rd <= r;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge mclk);
	endtask

	// Random drive of the GPIO block, peripherals and outside pads
	always @(posedge mclk) begin
		{gpio_out, gpio_oe} <= $urandom;
		{ext_en, ext_val} <= $urandom;
		pr <= 16'($urandom);
	end

	// Reference model from pre-edge values, compared once the edge has landed
	always @(posedge mclk) begin
		if (reset) begin
			sel_m = 16'h0;
			e_out = 16'h0;
			e_oe = 16'h0;
			e_gin = 16'h0;
			e_fin = 14'h0;
			e_rd = 32'h0;
		end else begin
			e_rd = 32'h0;
			for (int p = 0; p < 3; p++) begin
				if (bus_rd && bus_addr === adr[p]) e_rd = img(p);
			end
			// Pads frozen while power saving
			if (!power_save) begin
				e_out = (sel_m & ao) | (~sel_m & gpio_out);
				e_oe = (sel_m & aoe) | (~sel_m & gpio_oe);
			end
			e_gin = pin_in;
			e_fin = {~sel_m[7] & pin_in[7], ~sel_m[14] & pin_in[14], ~sel_m[15] & pin_in[15],
				~sel_m[14] & pin_in[14], ~sel_m[7] & pin_in[7], ~sel_m[4] & pin_in[4],
				sel_m[10] & pin_in[10], sel_m[9] & pin_in[9], ~sel_m[7] | pin_in[7], ~sel_m[5] | pin_in[5],
				sel_m[3] & pin_in[3], sel_m[2] & pin_in[2], sel_m[1] & pin_in[1], ~sel_m[0] | pin_in[0]};
			// Writes land only on mapped addresses outside power saving
			for (int p = 0; p < 3; p++) begin
				for (int i = 0; i < 7; i++) begin
					if (bus_wr && !power_save && bus_addr === adr[p] && (p < 2 || i < 2)) begin
						sel_m[7 * p + i] = (bus_wdata[4 * i +: 2] === GPFM_CODE_ALT);
					end
				end
			end
		end
		#1;
		if (!reset) begin
			chk("pin_oe", 32'(e_oe), 32'(pin_oe));
			chk("pin_out", 32'(e_out), 32'(pin_out));
			chk("gpio_in", 32'(e_gin), 32'(gpio_in));
			chk("periph_in", 32'(e_fin), 32'(fin));
			chk("bus_rdata", e_rd, bus_rdata);
		end
	end

	// Watchdog well beyond the few hundred cycles of the sequence
	initial begin
		#125000;
		n_mismatch++;
		give_verdict();
	end

	// Main sequence
	initial begin
		logic [31:0] r;
		void'($urandom(32'hAE74));
		reset = 1'h1;
		power_save = 1'h0;
		bus_wr = 1'h0;
		bus_rd = 1'h0;
		bus_addr = 32'h0;
		bus_wdata = 32'h0;
		{gpio_out, gpio_oe, ext_en, ext_val, pr} = 80'h0;
		adr = '{GPFM_PORT0_SEL_ADDR, GPFM_PORT1_SEL_ADDR, GPFM_PORT2_SEL_ADDR, 32'hFFFF0D0C};
		repeat (3) @(posedge mclk);
		reset <= 1'h0;
		// Reset images read back as zero
		for (int p = 0; p < 3; p++) op(1'h0, 1'h1, adr[p], 32'h0);
		// Every code in every field, reserved pairs set, read back at once
		for (int c = 0; c < 4; c++) begin
			for (int p = 0; p < 3; p++) begin
				op(1'h1, 1'h0, adr[p], {8{2'h3, c[1:0]}});
				op(1'h0, 1'h1, adr[p], 32'h0);
			end
			repeat (6) op(1'h0, 1'h0, adr[0], 32'h0);
		end
		// Random traffic, unmapped address and power saving among it
		for (int k = 0; k < 200; k++) begin
			r = $urandom;
			power_save <= (r[6:4] == 3'h0);
			op(r[0], ~r[0] & r[1], adr[r[3:2]], $urandom);
		end
		// Write refused and pads frozen during power saving
		power_save <= 1'h0;
		op(1'h1, 1'h0, adr[0], 32'h01111111);
		power_save <= 1'h1;
		op(1'h1, 1'h0, adr[0], 32'h0);
		op(1'h0, 1'h1, adr[0], 32'h0);
		repeat (5) op(1'h0, 1'h0, adr[0], 32'h0);
		power_save <= 1'h0;
		// Reset in mid-run clears a configured port
		op(1'h1, 1'h0, adr[1], 32'h01111111);
		reset <= 1'h1;
		repeat (2) op(1'h0, 1'h0, adr[0], 32'h0);
		reset <= 1'h0;
		for (int p = 0; p < 3; p++) op(1'h0, 1'h1, adr[p], 32'h0);
		repeat (3) op(1'h0, 1'h0, adr[0], 32'h0);
		give_verdict();
	end
endmodule

`default_nettype wire
